/* File: rtl/retimer_pkg.sv */
// Package for the retimer channel output select control block.
// Assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
package retimer_pkg;

	// Register byte offsets
	localparam logic [7:0] adr_override = 8'h24; // Override control bits
	localparam logic [7:0] adr_force_detect = 8'h50; // Force signal detect pair
	localparam logic [7:0] adr_divider = 8'h60; // Divider field
	localparam logic [7:0] adr_mux_field = 8'h78; // Output source and clock enable
	localparam logic [7:0] adr_start_ctl = 8'hBC; // Start index override enable
	localparam logic [7:0] adr_start_idx = 8'hE4; // Start index field
	localparam logic [7:0] adr_status = 8'hF0; // Live channel status
	localparam logic [7:0] adr_table_base = 8'h00; // Boost table base, second page
	localparam logic adr_table_page = 1'b1; // Address bit 8 selects the table

	// Field positions
	localparam int bit_quad_en_a = 4; // Quadrature enable in override register
	localparam int bit_mux_ovr = 5; // Mux override
	localparam int bit_div_ovr = 2; // Divider override
	localparam int bit_force_hi = 7; // Force detect upper bit
	localparam int bit_force_lo = 6; // Force detect lower bit
	localparam int bit_start_ovr = 3; // Start index override
	localparam int bit_quad_en_b = 0; // Quadrature enable in mux register
	localparam int bit_pattern_en = 4; // Pattern generator enable
	localparam int src_lsb = 5; // Output source field low bit
	localparam int div_lsb = 4; // Divider field low bit

	// Widths
	localparam int idx_w = 5; // Adaptation index width
	localparam int table_depth = 32; // Boost table entries
	localparam logic [2:0] div_max = 3'h4; // Largest valid divider code

	// Reset values
	localparam logic [7:0] rst_override = 8'h00;
	localparam logic [7:0] rst_force = 8'h00;
	localparam logic [7:0] rst_divider = 8'h00;
	localparam logic [7:0] rst_mux = 8'hE0; // Source field at mute
	localparam logic [7:0] rst_start_ctl = 8'h00;
	localparam logic [7:0] rst_start_idx = 8'h00;

	// Output source codes
	typedef enum logic [2:0] {
		src_raw = 3'h0,
		src_retimed = 3'h1,
		src_clk_i = 3'h2,
		src_clk_q = 3'h3,
		src_pattern = 3'h4,
		src_clk_10m = 3'h5,
		src_invalid = 3'h6,
		src_mute = 3'h7
	} out_src_t;

	// Equalizer boost entry: four two-bit stages, stage 0 in the top bits
	typedef logic [7:0] boost_entry_t;

	// Adaptation request and answer
	typedef struct packed {
		logic start; // Begin adaptation
		logic [3:0] figure_of_merit; // Figure of merit of the current entry
		logic fom_valid; // Figure of merit strobe
	} adapt_in_t;

	typedef struct packed {
		logic busy; // Walk in progress
		logic [4:0] index; // Current table index
		boost_entry_t boost; // Boost setting applied now
		logic done; // One cycle at completion
	} adapt_out_t;

	// Channel output control
	typedef struct packed {
		out_src_t src; // Selected source
		logic chan_en; // Channel and driver powered
		logic osc_free; // Oscillator free-running
		logic [4:0] div_ratio; // One-hot style ratio 1..16 as shift
		logic [2:0] div_code; // Divider code 0..4
	} chan_ctl_t;

	// AHB transfer type and response codes
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [1:0] hresp_okay = 2'h0;

	// Table defaults, index 0 first
	localparam boost_entry_t boost_default [table_depth] = '{
		8'h00, 8'h01, 8'h04, 8'h10, 8'h40, 8'h08, 8'h02, 8'h80,
		8'h03, 8'h0C, 8'h30, 8'h41, 8'h50, 8'hC0, 8'h60, 8'h90,
		8'h88, 8'h82, 8'hA0, 8'h46, 8'h52, 8'h8C, 8'hB0, 8'hC8,
		8'h57, 8'h5D, 8'h69, 8'h75, 8'hD5, 8'h99, 8'h96, 8'hA5
	};

endpackage : retimer_pkg

/* File: rtl/retimer_output_select_ctl.sv */
// Channel output select, signal detect force, divider override and
// equalizer adaptation index walk for one retimer channel.
// Assumes an AHB-Lite master on hclk; analog status pins are asynchronous.
//
// Behaviour
// - Start index from field when override set
// - Index zero walks table until best merit
// - No signal detected powers channel down, muted
// - Three-bit source code selects output
// - Unoverridden field applies only when unlocked
// - Source field resets to mute code
// - Mux override drives field regardless lock
// - Force pair one-zero forces detect on
// - Both force bits clear restores detection
// - Locked clocks and pattern follow input
// - No lock: oscillator free-runs by divider
// - Overridden mux allows free 10 MHz clock
// - Automatic divide ratio from input rate
// - Divider override takes ratio from field
// - Divider codes 0..4 give 1..16
// - Boost table of 32 four-stage entries
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module retimer_output_select_ctl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sig_detect_pin,
	input wire logic lock_pin,
	input wire logic [2:0] auto_div_code,
	input wire retimer_pkg::adapt_in_t adapt_in,
	output retimer_pkg::adapt_out_t adapt_out,
	output retimer_pkg::chan_ctl_t chan_ctl,
	output logic quad_clk_en,
	output logic pattern_en
);
	import retimer_pkg::*;

	// Control registers
	logic [7:0] override_r;
	logic [7:0] force_r;
	logic [7:0] divider_r;
	logic [7:0] mux_r;
	logic [7:0] start_ctl_r;
	logic [7:0] start_idx_r;
	boost_entry_t table_r [table_depth];

	// Address phase capture
	logic wr_pend_r;
	logic [8:0] wr_addr_r;
	logic [31:0] rd_data_r;

	// Synchronised status pins
	logic det_s1_r, det_s2_r, lock_s1_r, lock_s2_r;

	// Derived status
	logic detect_eff;
	logic detect_forced;
	out_src_t src_nxt;
	logic [2:0] div_nxt;

	// Adaptation walk
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_walk = 3'b010,
		st_best = 3'b100
	} adapt_state_t;
	adapt_state_t st_r;
	logic [4:0] idx_r;
	logic [4:0] best_idx_r;
	logic [3:0] best_fom_r;
	logic [3:0] beyond_r;
	localparam logic [3:0] look_beyond = 4'h2; // Trials past a drop
	localparam logic [4:0] idx_last = 5'h1F; // Last table index

	logic acc;
	assign acc = hsel && hready && (htrans == htrans_nonseq);

	// Two-flop synchronisers for analog status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			det_s1_r <= 1'b0;
			det_s2_r <= 1'b0;
			lock_s1_r <= 1'b0;
			lock_s2_r <= 1'b0;
		end else begin
			det_s1_r <= sig_detect_pin;
			det_s2_r <= det_s1_r;
			lock_s1_r <= lock_pin;
			lock_s2_r <= lock_s1_r;
		end
	end

	// Write address capture for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else begin
			wr_pend_r <= acc && hwrite;
			if (acc) begin
				wr_addr_r <= haddr[8:0];
			end
		end
	end

	// Control register writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			override_r <= rst_override;
			force_r <= rst_force;
			divider_r <= rst_divider;
			mux_r <= rst_mux;
			start_ctl_r <= rst_start_ctl;
			start_idx_r <= rst_start_idx;
		end else if (wr_pend_r && (wr_addr_r[8] != adr_table_page)) begin
			// Address decode
			if (wr_addr_r[7:0] == adr_override) begin
				override_r <= hwdata[7:0];
			end else if (wr_addr_r[7:0] == adr_force_detect) begin
				force_r <= hwdata[7:0];
			end else if (wr_addr_r[7:0] == adr_divider) begin
				divider_r <= hwdata[7:0];
			end else if (wr_addr_r[7:0] == adr_mux_field) begin
				mux_r <= hwdata[7:0];
			end else if (wr_addr_r[7:0] == adr_start_ctl) begin
				start_ctl_r <= hwdata[7:0];
			end else if (wr_addr_r[7:0] == adr_start_idx) begin
				start_idx_r <= hwdata[7:0];
			end
		end
	end

	// Boost table, one entry per word
	genvar gi;
	generate
		for (gi = 0; gi < table_depth; gi++) begin : g_table
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					table_r[gi] <= boost_default[gi];
				end else if (wr_pend_r && (wr_addr_r[8] == adr_table_page)
						&& (wr_addr_r[6:2] == 5'(gi)) && (wr_addr_r[7] == 1'b0)) begin
					table_r[gi] <= hwdata[7:0];
				end
			end
		end
	endgenerate

	// Read data, registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data_r <= '0;
		end else if (acc && !hwrite) begin
			rd_data_r <= '0;
			if (haddr[8] == adr_table_page) begin
				if (haddr[7] == 1'b0) begin
					rd_data_r <= {24'h000000, table_r[haddr[6:2]]};
				end
			end else if (haddr[7:0] == adr_override) begin
				rd_data_r <= {24'h000000, override_r};
			end else if (haddr[7:0] == adr_force_detect) begin
				rd_data_r <= {24'h000000, force_r};
			end else if (haddr[7:0] == adr_divider) begin
				rd_data_r <= {24'h000000, divider_r};
			end else if (haddr[7:0] == adr_mux_field) begin
				rd_data_r <= {24'h000000, mux_r};
			end else if (haddr[7:0] == adr_start_ctl) begin
				rd_data_r <= {24'h000000, start_ctl_r};
			end else if (haddr[7:0] == adr_start_idx) begin
				rd_data_r <= {24'h000000, start_idx_r};
			end else if (haddr[7:0] == adr_status) begin
				// Live status word
				rd_data_r <= {13'h0000, idx_r, 4'h0, chan_ctl.div_code,
					chan_ctl.src, chan_ctl.osc_free, chan_ctl.chan_en,
					lock_s2_r, detect_eff};
			end
		end
	end

	assign hrdata = rd_data_r;
	assign hreadyout = 1'b1;
	assign hresp = hresp_okay[0];

	assign detect_forced = force_r[bit_force_hi] && !force_r[bit_force_lo];
	assign detect_eff = detect_forced || det_s2_r;

	always_comb begin
		if (!detect_eff) begin
			src_nxt = src_mute;
		end else if (override_r[bit_mux_ovr]) begin
			src_nxt = out_src_t'(mux_r[src_lsb +: 3]);
		end else if (lock_s2_r) begin
			src_nxt = src_retimed;
		end else begin
			src_nxt = out_src_t'(mux_r[src_lsb +: 3]);
		end
		// Invalid code drives nothing
		if (src_nxt == src_invalid) begin
			src_nxt = src_mute;
		end
	end

	always_comb begin
		if (override_r[bit_div_ovr]) begin
			div_nxt = divider_r[div_lsb +: 3];
		end else begin
			div_nxt = auto_div_code;
		end
		// Codes above 4 clamp to 4
		if (div_nxt > div_max) begin
			div_nxt = div_max;
		end
	end

	// Registered channel control outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_ctl <= '{src: src_mute, chan_en: 1'b0, osc_free: 1'b1,
				div_ratio: 5'h01, div_code: 3'h0};
			quad_clk_en <= 1'b0;
			pattern_en <= 1'b0;
		end else begin
			chan_ctl.src <= src_nxt;
			chan_ctl.chan_en <= detect_eff;
			// Free-run without lock, else tracks input
			chan_ctl.osc_free <= !lock_s2_r;
			chan_ctl.div_ratio <= 5'h01 << div_nxt;
			chan_ctl.div_code <= div_nxt;
			quad_clk_en <= override_r[bit_quad_en_a] && mux_r[bit_quad_en_b];
			pattern_en <= mux_r[bit_pattern_en];
		end
	end

	// Adaptation walk state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= st_idle;
			idx_r <= '0;
			best_idx_r <= '0;
			best_fom_r <= '0;
			beyond_r <= '0;
		end else begin
			case (st_r)
				st_idle: begin
					if (adapt_in.start) begin
						idx_r <= start_ctl_r[bit_start_ovr] ? start_idx_r[idx_w-1:0] : '0;
						best_idx_r <= start_ctl_r[bit_start_ovr] ? start_idx_r[idx_w-1:0] : '0;
						best_fom_r <= '0;
						beyond_r <= '0;
						st_r <= st_walk;
					end
				end
				st_walk: begin
					if (adapt_in.fom_valid) begin
						if (adapt_in.figure_of_merit > best_fom_r) begin
							best_fom_r <= adapt_in.figure_of_merit;
							best_idx_r <= idx_r;
							beyond_r <= '0;
						end else begin
							beyond_r <= beyond_r + 4'h1;
						end
						if (idx_r == idx_last || (adapt_in.figure_of_merit <= best_fom_r && beyond_r >= look_beyond)) begin
							st_r <= st_best;
						end else begin
							idx_r <= idx_r + 5'h01;
						end
					end
				end
				st_best: begin
					idx_r <= best_idx_r;
					st_r <= st_idle;
				end
				default: st_r <= st_idle;
			endcase
		end
	end

	// Adaptation outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adapt_out <= '0;
		end else begin
			adapt_out.busy <= (st_r != st_idle);
			adapt_out.index <= (st_r == st_best) ? best_idx_r : idx_r;
			adapt_out.boost <= table_r[(st_r == st_best) ? best_idx_r : idx_r];
			adapt_out.done <= (st_r == st_best);
		end
	end

endmodule : retimer_output_select_ctl

/* File: verif/retimer_monitor.sv */
// Port-level checker for the channel output select block.
// Assumes bind onto the top module; mirrors override writes seen on the bus.
`timescale 1ns/1ps
module retimer_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic sig_detect_pin,
	input wire logic lock_pin,
	input wire retimer_pkg::adapt_in_t adapt_in,
	input wire retimer_pkg::adapt_out_t adapt_out,
	input wire retimer_pkg::chan_ctl_t chan_ctl
);
	import retimer_pkg::*;
	logic wr_r; // Write data phase pending
	logic [7:0] wa_r; // Its byte offset
	logic frc_r; // Force detect on
	logic ovr_r; // Mux override
	out_src_t fld_r; // Source field
	out_src_t exp_src; // Field as driven
	assign exp_src = (fld_r == src_invalid) ? src_mute : fld_r;
	// Mirror of override bits, updated at data phase end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			wa_r <= 8'h00;
			frc_r <= 1'b0;
			ovr_r <= 1'b0;
			fld_r <= src_mute;
		end else begin
			wr_r <= hsel && hready && htrans == htrans_nonseq && hwrite && haddr[31:8] == 24'h0;
			wa_r <= haddr[7:0];
			if (wr_r && wa_r == adr_force_detect) frc_r <= hwdata[7:6] == 2'b10;
			if (wr_r && wa_r == adr_override) ovr_r <= hwdata[bit_mux_ovr];
			if (wr_r && wa_r == adr_mux_field) fld_r <= out_src_t'(hwdata[7:5]);
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Condition held four edges with settings unchanged
	sequence s_hold(c);
		(c && $stable(fld_r) && $stable(ovr_r) && $stable(frc_r))[*4];
	endsequence
	AST_DIV_MAP: assert property (chan_ctl.div_ratio == 5'h01 << chan_ctl.div_code)
		else $error("divide ratio does not match code");
	AST_NO_INVALID: assert property (chan_ctl.src != src_invalid)
		else $error("invalid source driven");
	AST_OFF_MUTED: assert property (!chan_ctl.chan_en |-> chan_ctl.src == src_mute)
		else $error("powered down channel not muted");
	AST_LOCK_TRACK: assert property (s_hold(lock_pin) |-> !chan_ctl.osc_free)
		else $error("oscillator free while locked");
	AST_FREE_RUN: assert property (s_hold(!lock_pin) |-> chan_ctl.osc_free)
		else $error("oscillator not free while unlocked");
	AST_FORCE_ON: assert property (s_hold(frc_r) |-> chan_ctl.chan_en)
		else $error("forced detect left channel off");
	AST_AUTO_DETECT: assert property (s_hold(!frc_r && !sig_detect_pin) |-> !chan_ctl.chan_en)
		else $error("channel on with no signal");
	AST_LOCK_RETIMED: assert property (s_hold(!ovr_r && sig_detect_pin && lock_pin) |-> chan_ctl.src == src_retimed)
		else $error("locked channel not retimed");
	AST_UNLOCK_FIELD: assert property (s_hold(!ovr_r && sig_detect_pin && !lock_pin) |-> chan_ctl.src == exp_src)
		else $error("unlocked channel ignores field");
	AST_OVR_FIELD: assert property (s_hold(ovr_r && sig_detect_pin) |-> chan_ctl.src == exp_src)
		else $error("override ignores field");
	AST_DONE_PULSE: assert property (adapt_out.done |=> !adapt_out.done)
		else $error("done longer than one cycle");
	AST_START_BUSY: assert property (adapt_in.start && !adapt_out.busy |-> ##[1:2] adapt_out.busy)
		else $error("start not taken");
endmodule : retimer_monitor

bind retimer_output_select_ctl retimer_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .sig_detect_pin, .lock_pin, .adapt_in, .adapt_out, .chan_ctl);

/* File: verif/retimer_host.sv */
// Bus master model of the system controller, single word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps
module retimer_host (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [31:0] hwdata
);
	import retimer_pkg::*;
	int n_tmo = 0; // Waits that ran out
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end
	// Edge with hready high, bounded
	task automatic wait_rdy();
		int i;
		for (i = 0; i < 16; i++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		if (i == 16) n_tmo++;
	endtask : wait_rdy
	// Address phase, then data phase; released lines show a changed value
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= htrans_nonseq;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? wd : ~hwdata;
		wait_rdy();
		rd = hrdata;
		hwdata <= ~wd;
		haddr <= ~a;
	endtask : xfer
endmodule : retimer_host

/* File: verif/retimer_output_select_ctl_tb.sv */
// Self-checking bench for the channel output select block.
// Assumes the host model owns the bus; pins and adaptation driven here.
`timescale 1ns/1ps
module retimer_output_select_ctl_tb;
	import retimer_pkg::*;
	logic hclk = 1'b0; // 200 MHz
	logic hresetn = 1'b0;
	logic sig_detect_pin = 1'b0;
	logic lock_pin = 1'b0;
	logic [2:0] auto_div_code = 3'h3;
	adapt_in_t adapt_in = '0;
	logic hsel, hwrite, hreadyout, hresp, quad_clk_en, pattern_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	adapt_out_t adapt_out;
	chan_ctl_t chan_ctl;
	int n_fail = 0;
	int n_compared = 0;
	always #2.5 hclk = ~hclk;
	retimer_host u_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hwdata);
	retimer_output_select_ctl u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .sig_detect_pin, .lock_pin, .auto_div_code,
		.adapt_in, .adapt_out, .chan_ctl, .quad_clk_en, .pattern_en);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, {24'h0, d}, rd);
	endtask : wr
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0, rd);
		chk(rd, exp);
	endtask : rchk
	// Three edges: pin sync plus output register
	task automatic settle();
		repeat (3) @(posedge hclk);
		#1;
	endtask : settle
	task automatic pins(input logic s, input logic l);
		@(posedge hclk);
		sig_detect_pin <= s;
		lock_pin <= l;
		settle();
	endtask : pins
	task automatic figure_of_merit(input logic [3:0] f);
		@(posedge hclk);
		adapt_in.figure_of_merit <= f;
		adapt_in.fom_valid <= 1'b1;
		@(posedge hclk);
		adapt_in.fom_valid <= 1'b0;
	endtask : figure_of_merit
	task automatic start();
		@(posedge hclk);
		adapt_in.start <= 1'b1;
		@(posedge hclk);
		adapt_in.start <= 1'b0;
		@(posedge hclk);
		#1;
	endtask : start
	task automatic wait_done();
		int i;
		for (i = 0; i < 64; i++) begin
			if (adapt_out.done === 1'b1) break;
			@(posedge hclk);
			#1;
		end
		if (i == 64) begin
			n_fail++;
			stop_test();
		end
	endtask : wait_done
	task automatic stop_test();
		n_fail += u_host.n_tmo;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(adr_mux_field, 32'hE0);
		chk(chan_ctl.src, src_mute);
		rchk(32'h114, boost_default[5]);
		rchk(32'h17C, boost_default[31]);
		wr(32'h04, 8'hFF);
		rchk(32'h04, 32'h0);
		$display("reset test done");
		pins(1'b1, 1'b1);
		chk(chan_ctl.src, src_retimed);
		pins(1'b1, 1'b0);
		chk(chan_ctl.src, src_mute);
		wr(adr_mux_field, 8'h00);
		settle();
		chk(chan_ctl.src, src_raw);
		pins(1'b1, 1'b1);
		wr(adr_mux_field, 8'hF1);
		wr(adr_override, 8'h30);
		for (int c = 0; c < 8; c++) begin
			wr(adr_mux_field, {c[2:0], 5'h11});
			settle();
			chk(chan_ctl.src, (c == 6) ? 32'(src_mute) : 32'(c));
		end
		chk({quad_clk_en, pattern_en}, 2'b11);
		$display("source test done");
		wr(adr_mux_field, 8'h91);
		pins(1'b0, 1'b0);
		chk(chan_ctl.chan_en, 1'b0);
		wr(adr_force_detect, 8'h80);
		settle();
		chk(chan_ctl.src, src_pattern);
		wr(adr_force_detect, 8'h00);
		settle();
		chk(chan_ctl.chan_en, 1'b0);
		rchk(adr_status, 32'h000001F8);
		$display("force test done");
		chk(chan_ctl.div_ratio, 5'h08);
		wr(adr_override, 8'h04);
		for (int d = 0; d < 8; d++) begin
			wr(adr_divider, {1'b0, d[2:0], 4'h0});
			settle();
			chk(chan_ctl.div_ratio, 32'h1 << ((d > 4) ? 4 : d));
		end
		chk(quad_clk_en, 1'b0);
		wr(adr_override, 8'h00);
		auto_div_code <= 3'h1;
		settle();
		chk(chan_ctl.div_ratio, 5'h02);
		$display("divider test done");
		start();
		for (int i = 0; i < 6; i++) begin
			chk(adapt_out.index, i);
			chk(adapt_out.boost, boost_default[i]);
			figure_of_merit(4'((i < 3) ? i + 1 : 0));
			@(posedge hclk);
			#1;
		end
		wait_done();
		chk({adapt_out.index, adapt_out.boost}, {5'd2, boost_default[2]});
		wr(adr_start_ctl, 8'h08);
		wr(adr_start_idx, 8'h1F);
		start();
		chk(adapt_out.index, 5'h1F);
		figure_of_merit(4'h5);
		wait_done();
		chk(adapt_out.index, 5'h1F);
		$display("adaptation test done");
		stop_test();
	end
endmodule : retimer_output_select_ctl_tb
